// File: logic/sscs_pkg.sv
package sscs_pkg;
   localparam int WORD_W = 8;
   localparam int BITS_W = 4;
   localparam int DIV_W = 8;
   localparam int LEN_W = 9;
   localparam logic [1:0] HALT_LATE_SEL = 2'h2;
   localparam logic [1:0] HALT_EARLY_SEL = 2'h3;
   localparam logic SRC_CPU_SEL = 1'h1;
   localparam logic [BITS_W-1:0] BITS_FULL = 4'h8;
   localparam logic [BITS_W-1:0] BITS_LAST = 4'h7;
   localparam logic [LEN_W-1:0] LEN_MIN = 9'h001;
   localparam logic SYNC_PIN_RESET = 1'h1;
   localparam int CLK_PERIOD_NS = 10;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_HIGH,
      ST_LOW,
      ST_DREL,
      ST_SREL,
      ST_SLAVE
   } sscs_state_e;
endpackage

// File: logic/sscs_rate_gen.sv
`timescale 1ns/1ns
module sscs_rate_gen
   import sscs_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic src_sel_in,
   input wire logic ext_clk_in,
   input wire logic load_in,
   input wire logic [LEN_W-1:0] len_in,
   output logic expire_out
);
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic busy_r;
   logic [LEN_W-1:0] cnt_r;
   wire ext_rise = ext_s2_r & ~ext_s3_r;
   // One tick per generator input period.
   wire tick = (src_sel_in == SRC_CPU_SEL) ? 1'b1 : ext_rise; // RL12
   wire last_tick = busy_r & tick & (cnt_r == LEN_MIN);

   assign expire_out = last_tick; // RL10

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else if (ce_in) begin
         ext_s1_r <= ext_clk_in;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         busy_r <= 1'b0;
         cnt_r <= LEN_MIN;
      end else if (ce_in) begin
         if (load_in) begin
            busy_r <= 1'b1;
            cnt_r <= len_in;
         end else if (last_tick) begin
            busy_r <= 1'b0;
         end else if (busy_r && tick) begin
            cnt_r <= cnt_r - LEN_MIN;
         end
      end
   end
endmodule

// File: logic/sscs_port.sv
// Notes on behaviour
// [RL1] Mode 10b: sample receive data on falling edge.
// [RL2] Mode 10b: launch transmit bits on rising edge.
// [RL3] Mode 11b: sample receive data on rising edge.
// [RL4] Mode 11b: launch transmit bits on falling edge.
// [RL5] Master enable leads: low phase, or period.
// [RL6] Master enable holds: period, or low phase.
// [RL7] Master releases data after last bit.
// [RL8] Slave releases data when enable returns high.
// [RL9] First bit valid after enable goes low.
// [RL10] Bit period equals input period times divide+1; divide 0 gives two input periods.
// [RL11] High and low phase lengths from divide.
// [RL12] Source select picks CPU or external clock.
// [RL13] Slave software sets source and divide 1.
// [RL14] Enable polarity inverted on output and input.
// [RL15] Master drives clock and sync, receives inputs.
// [RL16] Enable low before first rising clock edge.
// [RL17] Software keeps bit rate under the ceiling.
// [RL18] Master clock rests low between transfers.
`timescale 1ns/1ns
module sscs_port
   import sscs_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CE_IN,
   input wire logic MASTER_IN,
   input wire logic [1:0] CLOCK_HALT_PHASE_SELECT_IN,
   input wire logic TX_SYNC_POLARITY_IN,
   input wire logic RX_SYNC_POLARITY_IN,
   input wire logic RATE_GEN_SOURCE_SELECT_IN,
   input wire logic [DIV_W-1:0] BIT_CLOCK_DIVIDE_VALUE_IN,
   input wire logic EXT_RATE_CLOCK_IN,
   input wire logic START_IN,
   input wire logic [WORD_W-1:0] TX_WORD_IN,
   output logic BUSY_OUT,
   output logic [WORD_W-1:0] RX_WORD_OUT,
   output logic RX_VALID_OUT,
   output logic TX_CLOCK_DIRECTION_OUT,
   output logic TX_SYNC_DIRECTION_OUT,
   output logic RX_CLOCK_DIRECTION_OUT,
   output logic RX_SYNC_DIRECTION_OUT,
   input wire logic TX_BIT_CLOCK_IN,
   output logic TX_BIT_CLOCK_OUT,
   output logic TX_BIT_CLOCK_OE_OUT,
   input wire logic TX_FRAME_SYNC_IN,
   output logic TX_FRAME_SYNC_OUT,
   output logic TX_FRAME_SYNC_OE_OUT,
   input wire logic RX_FRAME_SYNC_IN,
   input wire logic SERIAL_RECEIVE_PIN_IN,
   output logic SERIAL_TRANSMIT_PIN_OUT,
   output logic SERIAL_TRANSMIT_PIN_OE_OUT
);
   // Even divide: high = div/2+1, low = div/2; odd: both (div+1)/2.
   function automatic logic [LEN_W-1:0] phase_len(
      input logic [DIV_W-1:0] div,
      input logic high
   );
      logic [LEN_W-1:0] half;
      logic [LEN_W-1:0] len;
      half = {1'b0, div} >> 1;
      if (div[0]) begin
         len = half + LEN_MIN; // RL11
      end else begin
         len = high ? half + LEN_MIN : half; // RL11
      end
      // A zero low phase cannot be timed; it becomes one input period.
      phase_len = (len == '0) ? LEN_MIN : len;
   endfunction

   sscs_state_e state_r, state_nxt;
   logic bclk_r, bclk_nxt;
   logic act_r, act_nxt;
   logic tx_oe_r, tx_oe_nxt;
   logic tx_bit_r, tx_bit_nxt;
   logic first_r, first_nxt;
   logic [WORD_W-1:0] tx_sh_r, tx_sh_nxt;
   logic [WORD_W-1:0] rx_sh_r, rx_sh_nxt;
   logic [WORD_W-1:0] rx_word_r, rx_word_nxt;
   logic [BITS_W-1:0] bits_r, bits_nxt;
   logic rx_valid_r, rx_valid_nxt;
   logic busy_r;
   logic load;
   logic [LEN_W-1:0] len;
   logic expire;
   logic sync_pin_r;
   logic master_r;
   logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
   logic sfx_s1_r, sfx_s2_r;
   logic sfr_s1_r, sfr_s2_r;
   logic sdr_s1_r, sdr_s2_r;

   wire late = CLOCK_HALT_PHASE_SELECT_IN != HALT_EARLY_SEL;
   wire [LEN_W-1:0] len_h = phase_len(BIT_CLOCK_DIVIDE_VALUE_IN, 1'b1);
   wire [LEN_W-1:0] len_l = phase_len(BIT_CLOCK_DIVIDE_VALUE_IN, 1'b0);
   wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
   wire sclk_fall = ~sclk_s2_r & sclk_s3_r;
   wire fx_act = TX_SYNC_POLARITY_IN ? ~sfx_s2_r : sfx_s2_r; // RL14
   wire fr_act = RX_SYNC_POLARITY_IN ? ~sfr_s2_r : sfr_s2_r; // RL14
   wire slave_en = fx_act | fr_act;
   wire [WORD_W-1:0] rx_shifted = {rx_sh_r[WORD_W-2:0], sdr_s2_r};
   wire [WORD_W-1:0] tx_shifted = {tx_sh_r[WORD_W-2:0], 1'b0};
   wire [BITS_W-1:0] bits_inc = bits_r + 4'h1;
   wire can_sample = bits_r != BITS_FULL;

   sscs_rate_gen u_rate_gen (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .ce_in(CE_IN),
      .src_sel_in(RATE_GEN_SOURCE_SELECT_IN),
      .ext_clk_in(EXT_RATE_CLOCK_IN),
      .load_in(load),
      .len_in(len),
      .expire_out(expire)
   );

   always_comb begin
      state_nxt = state_r;
      bclk_nxt = bclk_r;
      act_nxt = act_r;
      tx_oe_nxt = tx_oe_r;
      tx_bit_nxt = tx_bit_r;
      first_nxt = first_r;
      tx_sh_nxt = tx_sh_r;
      rx_sh_nxt = rx_sh_r;
      rx_word_nxt = rx_word_r;
      bits_nxt = bits_r;
      rx_valid_nxt = 1'b0;
      load = 1'b0;
      len = len_l;
      case (state_r)
         ST_IDLE: begin
            bclk_nxt = 1'b0; // RL18
            if (MASTER_IN && START_IN) begin
               act_nxt = 1'b1; // RL16
               tx_sh_nxt = TX_WORD_IN;
               bits_nxt = '0;
               load = 1'b1;
               len = late ? len_l : len_h; // RL5
               state_nxt = ST_LEAD;
            end else if (!MASTER_IN && slave_en) begin
               tx_oe_nxt = 1'b1; // RL9
               tx_bit_nxt = TX_WORD_IN[WORD_W-1];
               tx_sh_nxt = {TX_WORD_IN[WORD_W-2:0], 1'b0};
               bits_nxt = '0;
               first_nxt = 1'b1;
               state_nxt = ST_SLAVE;
            end
         end
         ST_LEAD: begin
            if (expire) begin
               tx_oe_nxt = 1'b1;
               tx_bit_nxt = tx_sh_r[WORD_W-1];
               tx_sh_nxt = tx_shifted;
               load = 1'b1;
               if (late) begin
                  bclk_nxt = 1'b1; // RL2
                  len = len_h;
                  state_nxt = ST_HIGH;
               end else begin
                  len = len_l; // RL9
                  state_nxt = ST_LOW;
               end
            end
         end
         ST_HIGH: begin
            if (expire) begin
               bclk_nxt = 1'b0;
               load = 1'b1;
               len = len_l;
               if (late) begin
                  rx_sh_nxt = rx_shifted; // RL1
                  bits_nxt = bits_inc;
                  state_nxt = (bits_r == BITS_LAST) ? ST_DREL : ST_LOW;
               end else if (bits_r == BITS_FULL) begin
                  tx_oe_nxt = 1'b0; // RL7
                  state_nxt = ST_SREL; // RL6
               end else begin
                  tx_bit_nxt = tx_sh_r[WORD_W-1]; // RL4
                  tx_sh_nxt = tx_shifted;
                  state_nxt = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            if (expire) begin
               bclk_nxt = 1'b1;
               load = 1'b1;
               len = len_h;
               state_nxt = ST_HIGH;
               if (late) begin
                  tx_bit_nxt = tx_sh_r[WORD_W-1]; // RL2
                  tx_sh_nxt = tx_shifted;
               end else begin
                  rx_sh_nxt = rx_shifted; // RL3
                  bits_nxt = bits_inc;
               end
            end
         end
         ST_DREL: begin
            if (expire) begin
               tx_oe_nxt = 1'b0; // RL7
               load = 1'b1;
               len = len_h; // RL6
               state_nxt = ST_SREL;
            end
         end
         ST_SREL: begin
            if (expire) begin
               act_nxt = 1'b0;
               rx_word_nxt = rx_sh_r;
               rx_valid_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (!slave_en) begin
               tx_oe_nxt = 1'b0; // RL8
               rx_word_nxt = rx_sh_r;
               rx_valid_nxt = !can_sample;
               state_nxt = ST_IDLE;
            end else if (sclk_rise) begin
               first_nxt = 1'b0;
               if (late && !first_r) begin
                  tx_bit_nxt = tx_sh_r[WORD_W-1]; // RL2
                  tx_sh_nxt = tx_shifted;
               end else if (!late && can_sample) begin
                  rx_sh_nxt = rx_shifted; // RL3
                  bits_nxt = bits_inc;
               end
            end else if (sclk_fall) begin
               if (!late) begin
                  tx_bit_nxt = tx_sh_r[WORD_W-1]; // RL4
                  tx_sh_nxt = tx_shifted;
               end else if (can_sample) begin
                  rx_sh_nxt = rx_shifted; // RL1
                  bits_nxt = bits_inc;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_s3_r <= 1'b0;
         sfx_s1_r <= SYNC_PIN_RESET;
         sfx_s2_r <= SYNC_PIN_RESET;
         sfr_s1_r <= SYNC_PIN_RESET;
         sfr_s2_r <= SYNC_PIN_RESET;
         sdr_s1_r <= 1'b0;
         sdr_s2_r <= 1'b0;
      end else if (CE_IN) begin
         sclk_s1_r <= TX_BIT_CLOCK_IN;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
         sfx_s1_r <= TX_FRAME_SYNC_IN;
         sfx_s2_r <= sfx_s1_r;
         sfr_s1_r <= RX_FRAME_SYNC_IN;
         sfr_s2_r <= sfr_s1_r;
         sdr_s1_r <= SERIAL_RECEIVE_PIN_IN;
         sdr_s2_r <= sdr_s1_r;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         state_r <= ST_IDLE;
         bclk_r <= 1'b0;
         act_r <= 1'b0;
         tx_oe_r <= 1'b0;
         tx_bit_r <= 1'b0;
         first_r <= 1'b0;
         tx_sh_r <= '0;
         rx_sh_r <= '0;
         rx_word_r <= '0;
         bits_r <= '0;
         rx_valid_r <= 1'b0;
         busy_r <= 1'b0;
         sync_pin_r <= SYNC_PIN_RESET;
         master_r <= 1'b0;
      end else if (CE_IN) begin
         state_r <= state_nxt;
         bclk_r <= bclk_nxt;
         act_r <= act_nxt;
         tx_oe_r <= tx_oe_nxt;
         tx_bit_r <= tx_bit_nxt;
         first_r <= first_nxt;
         tx_sh_r <= tx_sh_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_word_r <= rx_word_nxt;
         bits_r <= bits_nxt;
         rx_valid_r <= rx_valid_nxt;
         busy_r <= state_nxt != ST_IDLE;
         sync_pin_r <= act_nxt ^ TX_SYNC_POLARITY_IN; // RL14
         master_r <= MASTER_IN; // RL15
      end
   end

   assign BUSY_OUT = busy_r;
   assign RX_WORD_OUT = rx_word_r;
   assign RX_VALID_OUT = rx_valid_r;
   assign TX_CLOCK_DIRECTION_OUT = master_r;
   assign TX_SYNC_DIRECTION_OUT = master_r;
   assign RX_CLOCK_DIRECTION_OUT = 1'b0;
   assign RX_SYNC_DIRECTION_OUT = 1'b0;
   assign TX_BIT_CLOCK_OUT = bclk_r;
   assign TX_BIT_CLOCK_OE_OUT = master_r;
   assign TX_FRAME_SYNC_OUT = sync_pin_r;
   assign TX_FRAME_SYNC_OE_OUT = master_r;
   assign SERIAL_TRANSMIT_PIN_OUT = tx_bit_r;
   assign SERIAL_TRANSMIT_PIN_OE_OUT = tx_oe_r;
endmodule

// File: tb/sscs_port_monitor.sv
`timescale 1ns/1ns
module sscs_port_monitor
   import sscs_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic MASTER_IN,
   input wire logic [1:0] CLOCK_HALT_PHASE_SELECT_IN,
   input wire logic TX_SYNC_POLARITY_IN,
   input wire logic RATE_GEN_SOURCE_SELECT_IN,
   input wire logic [DIV_W-1:0] BIT_CLOCK_DIVIDE_VALUE_IN,
   input wire logic BUSY_OUT,
   input wire logic TX_CLOCK_DIRECTION_OUT,
   input wire logic TX_SYNC_DIRECTION_OUT,
   input wire logic RX_CLOCK_DIRECTION_OUT,
   input wire logic RX_SYNC_DIRECTION_OUT,
   input wire logic TX_BIT_CLOCK_OUT,
   input wire logic TX_FRAME_SYNC_OUT,
   input wire logic TX_FRAME_SYNC_IN,
   input wire logic SERIAL_TRANSMIT_PIN_OUT,
   input wire logic SERIAL_TRANSMIT_PIN_OE_OUT
);
   logic clk_q_r, sync_q_r, seen_r;
   logic [8:0] run_r, srun_r;
   wire early = CLOCK_HALT_PHASE_SELECT_IN == HALT_EARLY_SEL;
   wire m = MASTER_IN && RATE_GEN_SOURCE_SELECT_IN == SRC_CPU_SEL;
   wire act = TX_FRAME_SYNC_OUT != TX_SYNC_POLARITY_IN;
   wire clk = TX_BIT_CLOCK_OUT;
   wire oe = SERIAL_TRANSMIT_PIN_OE_OUT;
   wire [8:0] dx = {1'b0, BIT_CLOCK_DIVIDE_VALUE_IN};
   wire [8:0] hi = dx[0] ? (dx + 9'h001) >> 1 : (dx >> 1) + 9'h001;
   wire [8:0] lo = (dx == 9'h000) ? 9'h001 : (dx[0] ? hi : dx >> 1);
   // Cycles that the bit clock and the sync pin have held their level.
   wire [8:0] run_nxt = (clk != clk_q_r) ? 9'h001 :
      run_r + {8'h00, run_r != 9'h1FF};
   wire [8:0] srun_nxt = (TX_FRAME_SYNC_OUT != sync_q_r) ? 9'h001 :
      srun_r + {8'h00, srun_r != 9'h1FF};
   wire seen_nxt = BUSY_OUT && (seen_r || clk);
   always_ff @(posedge CLK_IN) begin
      clk_q_r <= clk;
      sync_q_r <= TX_FRAME_SYNC_OUT;
      run_r <= run_nxt;
      srun_r <= srun_nxt;
      seen_r <= seen_nxt;
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   AST_IDLE_LOW: assert property (!BUSY_OUT |-> !clk)
      else $error("bit clock not low while idle");
   AST_ROLE_DIRS: assert property (BUSY_OUT && MASTER_IN |->
      TX_CLOCK_DIRECTION_OUT && TX_SYNC_DIRECTION_OUT &&
      !RX_CLOCK_DIRECTION_OUT && !RX_SYNC_DIRECTION_OUT)
      else $error("pin directions wrong for master");
   AST_FIRST_RISE: assert property (m && $rose(clk) && !seen_r |->
      act && srun_r == (early ? hi + lo : lo))
      else $error("enable lead before first rise wrong");
   AST_HIGH_LEN: assert property (m && $fell(clk) |-> run_r == hi)
      else $error("high phase length wrong");
   AST_LOW_LEN: assert property (m && $rose(clk) && seen_r |-> run_r == lo)
      else $error("low phase length wrong");
   AST_SYNC_HOLD: assert property (m && $past(BUSY_OUT) &&
      $changed(TX_FRAME_SYNC_OUT) && !act |->
      !clk && run_r == (early ? lo : hi + lo))
      else $error("enable hold after last fall wrong");
   AST_DATA_REL: assert property (m && $fell(oe) |->
      (early ? $fell(clk) : (!clk && run_r == lo)))
      else $error("data release time wrong");
   AST_LAUNCH: assert property (MASTER_IN && oe && $past(oe) &&
      $changed(SERIAL_TRANSMIT_PIN_OUT) |-> (early ? $fell(clk) : $rose(clk)))
      else $error("data launched on wrong edge");
   AST_FIRST_BIT: assert property (m && early && $rose(oe) |-> srun_r == hi)
      else $error("first bit not one high phase after enable");
   AST_SLAVE_REL: assert property (!MASTER_IN && $fell(oe) |->
      TX_FRAME_SYNC_IN == TX_SYNC_POLARITY_IN &&
      $past(TX_FRAME_SYNC_IN, 2) == TX_SYNC_POLARITY_IN)
      else $error("slave released data with enable active");
endmodule
bind sscs_port sscs_port_monitor u_mon (.*);

// File: tb/sscs_peer.sv
`timescale 1ns/1ns
module sscs_peer (
   input wire logic clk_in,
   input wire logic sck_in,
   input wire logic sel_n_in,
   input wire logic mosi_in,
   input wire logic early_in,
   input wire logic [7:0] word_in,
   output logic miso_out,
   output logic [7:0] got_out
);
   logic sck_q = 1'b0;
   logic [3:0] n = 4'h0;
   wire rise = !sck_q && sck_in;
   wire fall = sck_q && !sck_in;
   wire launch = early_in ? fall : rise;
   wire [3:0] nn = n + {3'h0, launch};
   wire [3:0] ix = early_in ? nn : nn - {3'h0, nn != 4'h0};
   wire [2:0] bi = (ix > 4'h7) ? 3'h0 : 3'h7 - ix[2:0];
   initial miso_out = 1'b0;
   initial got_out = 8'h00;
   always @(posedge clk_in) begin
      sck_q <= sck_in;
      if (sel_n_in) begin
         n <= 4'h0;
         // Released line: no pull, so the level keeps moving.
         miso_out <= ~miso_out;
      end else begin
         n <= nn;
         miso_out <= word_in[bi];
         if (early_in ? rise : fall) got_out <= {got_out[6:0], mosi_in};
      end
   end
endmodule

// File: tb/sscs_port_tb.sv
`timescale 1ns/1ns
module sscs_port_tb
   import sscs_pkg::*;
;
   logic CLK_IN = 1'b0, RESETN_IN = 1'b0, CE_IN = 1'b1, MASTER_IN = 1'b1;
   logic [1:0] CLOCK_HALT_PHASE_SELECT_IN = HALT_LATE_SEL;
   logic TX_SYNC_POLARITY_IN = 1'b1, RX_SYNC_POLARITY_IN = 1'b1;
   logic RATE_GEN_SOURCE_SELECT_IN = SRC_CPU_SEL, EXT_RATE_CLOCK_IN = 1'b0;
   logic [DIV_W-1:0] BIT_CLOCK_DIVIDE_VALUE_IN = 8'h01;
   logic START_IN = 1'b0, TX_BIT_CLOCK_IN = 1'b0, TX_FRAME_SYNC_IN = 1'b1;
   logic RX_FRAME_SYNC_IN = 1'b1, s_dat = 1'b0, peer_miso;
   logic [WORD_W-1:0] TX_WORD_IN = 8'h00, RX_WORD_OUT, peer_word = 8'h00;
   logic [WORD_W-1:0] peer_got;
   logic BUSY_OUT, RX_VALID_OUT, TX_CLOCK_DIRECTION_OUT, TX_SYNC_DIRECTION_OUT;
   logic RX_CLOCK_DIRECTION_OUT, RX_SYNC_DIRECTION_OUT, TX_BIT_CLOCK_OUT;
   logic TX_BIT_CLOCK_OE_OUT, TX_FRAME_SYNC_OUT, TX_FRAME_SYNC_OE_OUT;
   logic SERIAL_TRANSMIT_PIN_OUT, SERIAL_TRANSMIT_PIN_OE_OUT;
   wire SERIAL_RECEIVE_PIN_IN = MASTER_IN ? peer_miso : s_dat;
   int checked = 0, failures = 0, cyc = 0;
   sscs_port DUT (.*);
   sscs_peer u_peer (.clk_in(CLK_IN), .sck_in(TX_BIT_CLOCK_OUT),
      .sel_n_in(TX_FRAME_SYNC_OUT), .mosi_in(SERIAL_TRANSMIT_PIN_OUT),
      .early_in(CLOCK_HALT_PHASE_SELECT_IN == HALT_EARLY_SEL),
      .word_in(peer_word), .miso_out(peer_miso), .got_out(peer_got));
   always #5 CLK_IN = ~CLK_IN;
   always #16 EXT_RATE_CLOCK_IN = ~EXT_RATE_CLOCK_IN;
   task automatic wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge CLK_IN) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_valid;
      int t;
      t = 0;
      do begin
         @(posedge CLK_IN);
         #1;
         t++;
      end while (RX_VALID_OUT !== 1'b1 && t < 1000);
      check("rx_valid", {7'h00, RX_VALID_OUT}, 8'h01);
   endtask
   task automatic xfer(input logic [1:0] md, input logic src,
      input logic [7:0] dv, input logic [7:0] tw, input logic [7:0] pw,
      input logic rxc);
      @(posedge CLK_IN);
      CLOCK_HALT_PHASE_SELECT_IN <= md;
      RATE_GEN_SOURCE_SELECT_IN <= src;
      BIT_CLOCK_DIVIDE_VALUE_IN <= dv;
      TX_WORD_IN <= tw;
      peer_word <= pw;
      START_IN <= 1'b1;
      @(posedge CLK_IN);
      START_IN <= 1'b0;
      wait_valid();
      check("peer_word", peer_got, tw);
      if (rxc) check("rx_word", RX_WORD_OUT, pw);
      check("master_dirs", {2'h0, TX_BIT_CLOCK_OE_OUT, TX_FRAME_SYNC_OE_OUT,
         TX_CLOCK_DIRECTION_OUT, TX_SYNC_DIRECTION_OUT,
         RX_CLOCK_DIRECTION_OUT, RX_SYNC_DIRECTION_OUT}, 8'h3C);
      $display("master transfer %h done", tw);
   endtask
   task automatic slave(input logic [1:0] md, input logic [7:0] tw,
      input logic [7:0] mw);
      logic [7:0] got;
      logic early;
      early = md == HALT_EARLY_SEL;
      @(posedge CLK_IN);
      MASTER_IN <= 1'b0;
      CLOCK_HALT_PHASE_SELECT_IN <= md;
      RATE_GEN_SOURCE_SELECT_IN <= SRC_CPU_SEL;
      BIT_CLOCK_DIVIDE_VALUE_IN <= 8'h01;
      TX_WORD_IN <= tw;
      repeat (2) @(posedge CLK_IN);
      TX_FRAME_SYNC_IN <= 1'b0;
      s_dat <= mw[7];
      for (int i = 7; i >= 0; i--) begin
         repeat (8) @(posedge CLK_IN);
         if (i == 7) check("oe", {7'h00, SERIAL_TRANSMIT_PIN_OE_OUT}, 8'h01);
         if (early) got[i] = SERIAL_TRANSMIT_PIN_OUT;
         TX_BIT_CLOCK_IN <= 1'b1;
         if (!early) s_dat <= mw[i];
         repeat (8) @(posedge CLK_IN);
         if (!early) got[i] = SERIAL_TRANSMIT_PIN_OUT;
         TX_BIT_CLOCK_IN <= 1'b0;
         if (early && i > 0) s_dat <= mw[i-1];
      end
      check("slave_dirs", {2'h0, TX_BIT_CLOCK_OE_OUT, TX_FRAME_SYNC_OE_OUT,
         TX_CLOCK_DIRECTION_OUT, TX_SYNC_DIRECTION_OUT,
         RX_CLOCK_DIRECTION_OUT, RX_SYNC_DIRECTION_OUT}, 8'h00);
      repeat (8) @(posedge CLK_IN);
      TX_FRAME_SYNC_IN <= 1'b1;
      s_dat <= ~mw[0];
      wait_valid();
      check("slave_rx", RX_WORD_OUT, mw);
      check("slave_tx", got, tw);
      repeat (3) @(posedge CLK_IN);
      #1;
      check("oe_off", {7'h00, SERIAL_TRANSMIT_PIN_OE_OUT}, 8'h00);
      $display("slave transfer %h done", tw);
   endtask
   initial begin
      repeat (8) @(posedge CLK_IN);
      RESETN_IN <= 1'b1;
      repeat (2) @(posedge CLK_IN);
      xfer(HALT_LATE_SEL, SRC_CPU_SEL, 8'h07, 8'hA5, 8'h3C, 1'b1);
      xfer(HALT_EARLY_SEL, SRC_CPU_SEL, 8'h08, 8'h5A, 8'hC3, 1'b1);
      xfer(HALT_LATE_SEL, SRC_CPU_SEL, 8'h06, 8'h81, 8'h7E, 1'b1);
      xfer(HALT_EARLY_SEL, SRC_CPU_SEL, 8'h00, 8'hE7, 8'h18, 1'b0);
      xfer(HALT_LATE_SEL, SRC_CPU_SEL, 8'h00, 8'h24, 8'hDB, 1'b0);
      xfer(HALT_EARLY_SEL, 1'b0, 8'h03, 8'h99, 8'h66, 1'b1);
      slave(HALT_LATE_SEL, 8'h96, 8'h69);
      slave(HALT_EARLY_SEL, 8'h4B, 8'hB2);
      @(posedge CLK_IN);
      MASTER_IN <= 1'b1;
      CE_IN <= 1'b0;
      START_IN <= 1'b1;
      repeat (4) @(posedge CLK_IN);
      START_IN <= 1'b0;
      #1;
      check("frozen_busy", {7'h00, BUSY_OUT}, 8'h00);
      @(posedge CLK_IN);
      CE_IN <= 1'b1;
      $display("freeze test done");
      wrap_up();
   end
endmodule
